// [include/hub_cfg_pkg.sv]
// Shared constants for the hub power and port configuration register bank.
package hub_cfg_pkg;

   // Core clock rate of the register bank.
   localparam int unsigned CLK_MHZ = 100;

   // Register byte offsets on the internal serial-slave register port.
   localparam logic [7:0] ADDR_CFG_ONE    = 8'h07;
   localparam logic [7:0] ADDR_CFG_TWO    = 8'h08;
   localparam logic [7:0] ADDR_FIXED_PORT = 8'h09;
   localparam logic [7:0] ADDR_OFF_SELF   = 8'h0A;
   localparam logic [7:0] ADDR_OFF_BUS    = 8'h0B;
   localparam logic [7:0] ADDR_MAX_DRAW   = 8'h0C;

   // Address window that the configuration lock protects.
   localparam logic [7:0] LOCK_ADDR_LO = 8'h01;
   localparam logic [7:0] LOCK_ADDR_HI = 8'h10;

   // Reset value of every register, and the answer to an unmapped read.
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam logic [7:0] UNMAPPED_VAL  = 8'h00;

   // Field positions in configuration byte one.
   localparam int unsigned CFG1_POWER_BIT   = 7;
   localparam int unsigned CFG1_FS_ONLY_BIT = 5;
   localparam int unsigned CFG1_EOP_OFF_BIT = 3;
   localparam int unsigned CFG1_SENSE_HI    = 2;
   localparam int unsigned CFG1_SENSE_LO    = 1;

   // Field positions in configuration byte two.
   localparam int unsigned CONFIG_BYTE_TWO_DYNAMIC_BIT  = 7;
   localparam int unsigned CONFIG_BYTE_TWO_DELAY_HI     = 5;
   localparam int unsigned CONFIG_BYTE_TWO_DELAY_LO     = 4;
   localparam int unsigned CONFIG_BYTE_TWO_COMPOUND_BIT = 3;

   // Port bit layout shared by the fixed-port and port-off registers.
   localparam int unsigned PORT_COUNT     = 2;
   localparam int unsigned PORT_FIRST_BIT = 1;
   localparam logic [7:0]  PORT_BITS_MASK = 8'h06;

   // Overload sensing mode codes; any code with the upper bit set means none.
   localparam logic [1:0] SENSE_GANGED   = 2'h0;
   localparam logic [1:0] SENSE_RESERVED = 2'h1;

   // Overload delay select codes.
   localparam logic [1:0] DELAY_SEL_0 = 2'h0;
   localparam logic [1:0] DELAY_SEL_1 = 2'h1;
   localparam logic [1:0] DELAY_SEL_2 = 2'h2;
   localparam logic [1:0] DELAY_SEL_3 = 2'h3;

   // Overload delay times in milliseconds.
   localparam real OC_DELAY_0_MS = 0.1;
   localparam real OC_DELAY_1_MS = 2.0;
   localparam real OC_DELAY_2_MS = 4.0;
   localparam real OC_DELAY_3_MS = 6.0;

   // Overload delay times in core clock cycles.
   localparam int unsigned OC_DELAY_0_CYC = int'(OC_DELAY_0_MS * 1000.0 * CLK_MHZ);
   localparam int unsigned OC_DELAY_1_CYC = int'(OC_DELAY_1_MS * 1000.0 * CLK_MHZ);
   localparam int unsigned OC_DELAY_2_CYC = int'(OC_DELAY_2_MS * 1000.0 * CLK_MHZ);
   localparam int unsigned OC_DELAY_3_CYC = int'(OC_DELAY_3_MS * 1000.0 * CLK_MHZ);

   // One count of the maximum draw value stands for this many milliamps.
   localparam logic [8:0] DRAW_UNIT_MA = 9'h002;

   // Width of the overload delay counter.
   localparam int unsigned DELAY_CNT_W = 32;

endpackage

// [hdl/level_sync.sv]
// Two-flop synchroniser for a level arriving from outside the core clock domain.
`timescale 1ns/1ps
module level_sync
#(
   parameter logic IDLE_LEVEL = 1'b0
)
(
   input  wire logic i_clk_sys,
   input  wire logic i_rstn,
   input  wire logic i_async,
   output logic      o_sync
);

   typedef struct packed {
      logic first;
      logic second;
   } sync_s;

   sync_s sync_reg;
   sync_s sync_next;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_comb
   begin
      sync_next        = sync_reg;
      sync_next.first  = i_async;
      sync_next.second = sync_reg.first;
   end

   // Both stages start at the pin's idle level, so reset shows no false edge.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sync_reg <= {IDLE_LEVEL, IDLE_LEVEL};
      end
      else
      begin
         sync_reg <= sync_next;
      end
   end

   assign o_sync = sync_reg.second;

endmodule // level_sync

// [hdl/hold_timer.sv]
// Qualification timer: flags a condition that has held for a programmed number of cycles.
`timescale 1ns/1ps
module hold_timer
   import hub_cfg_pkg::*;
#(
   parameter int unsigned CNT_W = DELAY_CNT_W
)
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_rstn,
   input  wire logic             i_run,
   input  wire logic [CNT_W-1:0] i_limit,
   output logic                  o_expired
);

   if (CNT_W < 2)
   begin : g_bad_width
      $error("hold_timer needs a counter of at least two bits");
   end

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             expired;
   } timer_s;

   timer_s tmr_reg;
   timer_s tmr_next;

   // Any break in the condition restarts the count, so glitches never trip it.
   always_comb
   begin
      tmr_next = tmr_reg;
      if (!i_run)
      begin
         tmr_next.count   = '0;
         tmr_next.expired = 1'b0;
      end
      else if (!tmr_reg.expired)
      begin
         tmr_next.count = tmr_reg.count + {{(CNT_W-1){1'b0}}, 1'b1};
         if ((tmr_reg.count + {{(CNT_W-1){1'b0}}, 1'b1}) >= i_limit)
         begin
            tmr_next.expired = 1'b1;
         end
      end
   end

   // Counter and flag clear under reset.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         tmr_reg <= '0;
      end
      else
      begin
         tmr_reg <= tmr_next;
      end
   end

   assign o_expired = tmr_reg.expired;

endmodule // hold_timer

// [hdl/hub_power_port_config_regs.sv]
// Power, speed, overload and port configuration register bank of a two-port hub.
//
// Function
// [RULE1] Byte one bit 7 chooses bus power at 0, self power at 1.
// [RULE2] With dynamic switching on, the synchronised supply sense pin decides power mode.
// [RULE3] Byte one bit 5 high forces full-speed-only upstream attachment.
// [RULE4] Byte one bit 3 high suppresses the frame-end marker at full speed.
// [RULE5] Byte one bits 2:1 select ganged overload sensing, reserved, or none.
// [RULE6] Host uses no-sensing mode only with bus-powered configurations.
// [RULE7] Byte two bit 7 high enables automatic self/bus power switching.
// [RULE8] Byte two bits 5:4 pick overload delay 0.1, 2, 4 or 6 ms.
// [RULE9] Byte two bit 3 high marks the hub as part of a compound device.
// [RULE10] Fixed-port register bits 1 and 2 mark ports 1 and 2 non-removable.
// [RULE11] Fixed-port register bits 7:3 always read and hold zero.
// [RULE12] In self power, self port-off bits 1 and 2 disable ports 1 and 2.
// [RULE13] In bus power, bus port-off bits 1 and 2 disable ports 1 and 2.
// [RULE14] Port-off registers keep bit 0 and bits 7:3 at zero.
// [RULE15] Maximum draw value counts in 2 mA steps; 50 means 100 mA.
// [RULE16] Host never programs the maximum draw above 100 mA.
// [RULE17] Host adds a zero-reporting embedded function's draw to maximum draw.
// [RULE18] Once the configuration lock is set, writes to 0x01 through 0x10 are refused.
// [RULE19] Host writes only zero into reserved registers and bits.
// [RULE20] Registers read back the last write and hold 0x00 after hardware reset.
`timescale 1ns/1ps
module hub_power_port_config_regs
   import hub_cfg_pkg::*;
#(
   parameter int unsigned OC_CYC_0 = OC_DELAY_0_CYC,
   parameter int unsigned OC_CYC_1 = OC_DELAY_1_CYC,
   parameter int unsigned OC_CYC_2 = OC_DELAY_2_CYC,
   parameter int unsigned OC_CYC_3 = OC_DELAY_3_CYC
)
(
   input  wire logic                         i_clk_sys,
   input  wire logic                         i_rstn,
   input  wire logic                         i_wr_en,
   input  wire logic [7:0]                   i_wr_addr,
   input  wire logic [7:0]                   i_wr_data,
   input  wire logic                         i_rd_en,
   input  wire logic [7:0]                   i_rd_addr,
   input  wire logic                         i_config_lock,
   input  wire logic                         i_mem_clear,
   input  wire logic                         i_local_supply_sense_pin,
   input  wire logic                         i_overload_pin_n,
   output logic      [7:0]                   o_rd_data,
   output logic                              o_rd_valid,
   output logic                              o_wr_refused,
   output logic                              o_power_source_select,
   output logic                              o_full_speed_only,
   output logic                              o_frame_end_marker_off,
   output logic                              o_overload_sense_ganged,
   output logic                              o_overload_fault,
   output logic                              o_dynamic_switch_en,
   output logic                              o_compound_device,
   output logic      [hub_cfg_pkg::PORT_COUNT-1:0] o_fixed_port_mask,
   output logic      [hub_cfg_pkg::PORT_COUNT-1:0] o_port_enabled,
   output logic      [7:0]                   o_self_power_max_draw_value,
   output logic      [8:0]                   o_self_power_max_draw_ma
);

   // A delay count must fit the counter and be at least one cycle.
   if ((OC_CYC_0 < 1) || (OC_CYC_1 < 1) || (OC_CYC_2 < 1) || (OC_CYC_3 < 1))
   begin : g_bad_delay
      $error("overload delay counts must be at least one cycle");
   end

   typedef struct packed {
      logic [7:0]                  cfg_one;
      logic [7:0]                  cfg_two;
      logic [7:0]                  fixed_port;
      logic [7:0]                  off_self;
      logic [7:0]                  off_bus;
      logic [7:0]                  max_draw;
      logic [7:0]                  rd_data;
      logic                        rd_valid;
      logic                        wr_refused;
      logic                        self_power;
      logic                        fs_only;
      logic                        marker_off;
      logic                        ganged;
      logic                        dynamic;
      logic                        compound;
      logic [PORT_COUNT-1:0]       fixed_mask;
      logic [PORT_COUNT-1:0]       port_en;
      logic [8:0]                  draw_ma;
      logic [DELAY_CNT_W-1:0]      delay_cyc;
   } bank_s;

   bank_s bank_reg;
   bank_s bank_next;

   logic                  supply_sense;
   logic                  overload_n;
   logic                  overload_hit;
   logic                  power_self_now;
   logic [PORT_COUNT-1:0] port_off_now;
   logic [PORT_COUNT-1:0] port_fixed_now;
   logic [1:0]            sense_mode;
   logic [1:0]            delay_sel;
   logic                  wr_locked;

   // The supply sense pin is asynchronous to the core clock.
   level_sync u_supply_sync
   (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_async   (i_local_supply_sense_pin),
      .o_sync    (supply_sense)
   );

   // The overload flag pin is asynchronous to the core clock.
   level_sync #(.IDLE_LEVEL (1'b1)) u_overload_sync
   (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_async   (i_overload_pin_n),
      .o_sync    (overload_n)
   );

   // A fault counts only in ganged mode; other modes leave the pin unwatched.
   assign overload_hit = bank_reg.ganged && !overload_n;

   // The fault is reported only after the programmed delay of steady overload.
   hold_timer #(
      .CNT_W (DELAY_CNT_W)
   ) u_overload_timer
   (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_run     (overload_hit),
      .i_limit   (bank_reg.delay_cyc),
      .o_expired (o_overload_fault)
   );

   // Dynamic switching overrides the stored mode bit with the sensed supply.
   assign power_self_now = bank_reg.cfg_two[CONFIG_BYTE_TWO_DYNAMIC_BIT] ? supply_sense // [RULE2]
      : bank_reg.cfg_one[CFG1_POWER_BIT]; // [RULE1]

   assign sense_mode = bank_reg.cfg_one[CFG1_SENSE_HI:CFG1_SENSE_LO];
   assign delay_sel  = bank_reg.cfg_two[CONFIG_BYTE_TWO_DELAY_HI:CONFIG_BYTE_TWO_DELAY_LO];

   // The lock covers the whole configuration window, which holds all of this bank.
   assign wr_locked = i_config_lock && (i_wr_addr >= LOCK_ADDR_LO)
                      && (i_wr_addr <= LOCK_ADDR_HI); // [RULE18]

   // Each port picks its disable bit from the register of the current power mode.
   for (genvar p = 0; p < PORT_COUNT; p++)
   begin : g_port
      assign port_off_now[p]   = power_self_now ? bank_reg.off_self[PORT_FIRST_BIT + p] // [RULE12]
                                                : bank_reg.off_bus[PORT_FIRST_BIT + p]; // [RULE13]
      assign port_fixed_now[p] = bank_reg.fixed_port[PORT_FIRST_BIT + p]; // [RULE10]
   end

   // Register writes, reads and the decoded configuration outputs.
   always_comb
   begin
      bank_next            = bank_reg;
      bank_next.rd_valid   = 1'b0;
      bank_next.wr_refused = 1'b0;

      // A memory clear from the command register wins over any write in that cycle.
      if (i_mem_clear)
      begin
         bank_next.cfg_one    = REG_RESET_VAL; // [RULE20]
         bank_next.cfg_two    = REG_RESET_VAL;
         bank_next.fixed_port = REG_RESET_VAL;
         bank_next.off_self   = REG_RESET_VAL;
         bank_next.off_bus    = REG_RESET_VAL;
         bank_next.max_draw   = REG_RESET_VAL;
      end
      else if (i_wr_en && wr_locked)
      begin
         bank_next.wr_refused = 1'b1; // [RULE18]
      end
      else if (i_wr_en)
      begin
         // Unmapped offsets take the write silently and change nothing.
         case (i_wr_addr)
            ADDR_CFG_ONE:    bank_next.cfg_one    = i_wr_data; // [RULE20]
            ADDR_CFG_TWO:    bank_next.cfg_two    = i_wr_data;
            ADDR_FIXED_PORT: bank_next.fixed_port = i_wr_data & PORT_BITS_MASK; // [RULE11]
            ADDR_OFF_SELF:   bank_next.off_self   = i_wr_data & PORT_BITS_MASK; // [RULE14]
            ADDR_OFF_BUS:    bank_next.off_bus    = i_wr_data & PORT_BITS_MASK; // [RULE14]
            ADDR_MAX_DRAW:   bank_next.max_draw   = i_wr_data;
            default:         bank_next.max_draw   = bank_reg.max_draw;
         endcase
      end

      // Reads answer one cycle later from the stored bytes; unmapped reads give zero.
      if (i_rd_en)
      begin
         bank_next.rd_valid = 1'b1;
         case (i_rd_addr)
            ADDR_CFG_ONE:    bank_next.rd_data = bank_reg.cfg_one; // [RULE20]
            ADDR_CFG_TWO:    bank_next.rd_data = bank_reg.cfg_two;
            ADDR_FIXED_PORT: bank_next.rd_data = bank_reg.fixed_port;
            ADDR_OFF_SELF:   bank_next.rd_data = bank_reg.off_self;
            ADDR_OFF_BUS:    bank_next.rd_data = bank_reg.off_bus;
            ADDR_MAX_DRAW:   bank_next.rd_data = bank_reg.max_draw;
            default:         bank_next.rd_data = UNMAPPED_VAL;
         endcase
      end

      // Decoded controls lag the stored bytes by one cycle to keep outputs on flops.
      bank_next.self_power = power_self_now;                                // [RULE1]
      bank_next.fs_only    = bank_reg.cfg_one[CFG1_FS_ONLY_BIT];            // [RULE3]
      bank_next.marker_off = bank_reg.cfg_one[CFG1_EOP_OFF_BIT];            // [RULE4]
      bank_next.ganged     = (sense_mode == SENSE_GANGED);                  // [RULE5]
      bank_next.dynamic    = bank_reg.cfg_two[CONFIG_BYTE_TWO_DYNAMIC_BIT];            // [RULE7]
      bank_next.compound   = bank_reg.cfg_two[CONFIG_BYTE_TWO_COMPOUND_BIT];           // [RULE9]
      bank_next.fixed_mask = port_fixed_now;                                // [RULE10]
      bank_next.port_en    = ~port_off_now;                                 // [RULE12]
      bank_next.draw_ma    = {1'b0, bank_reg.max_draw} * DRAW_UNIT_MA;      // [RULE15]

      // Delay select maps onto cycle counts; changing it mid-fault keeps the count.
      case (delay_sel)
         DELAY_SEL_0: bank_next.delay_cyc = DELAY_CNT_W'(OC_CYC_0); // [RULE8]
         DELAY_SEL_1: bank_next.delay_cyc = DELAY_CNT_W'(OC_CYC_1); // [RULE8]
         DELAY_SEL_2: bank_next.delay_cyc = DELAY_CNT_W'(OC_CYC_2); // [RULE8]
         DELAY_SEL_3: bank_next.delay_cyc = DELAY_CNT_W'(OC_CYC_3); // [RULE8]
         default:     bank_next.delay_cyc = DELAY_CNT_W'(OC_CYC_3);
      endcase
   end

   // Hardware reset returns every mapped register to zero, sensing to ganged, both ports to enabled, and the delay to the shortest.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         bank_reg           <= '0;
         bank_reg.ganged    <= 1'b1;
         bank_reg.port_en   <= '1;
         bank_reg.delay_cyc <= DELAY_CNT_W'(OC_CYC_0);
      end
      else
      begin
         bank_reg <= bank_next;
      end
   end

   // Every output except o_overload_fault comes straight from the state register.
   assign o_rd_data                   = bank_reg.rd_data;
   assign o_rd_valid                  = bank_reg.rd_valid;
   assign o_wr_refused                = bank_reg.wr_refused;
   assign o_power_source_select       = bank_reg.self_power;
   assign o_full_speed_only           = bank_reg.fs_only;
   assign o_frame_end_marker_off      = bank_reg.marker_off;
   assign o_overload_sense_ganged     = bank_reg.ganged;
   assign o_dynamic_switch_en         = bank_reg.dynamic;
   assign o_compound_device           = bank_reg.compound;
   assign o_fixed_port_mask           = bank_reg.fixed_mask;
   assign o_port_enabled              = bank_reg.port_en;
   assign o_self_power_max_draw_value = bank_reg.max_draw;
   assign o_self_power_max_draw_ma    = bank_reg.draw_ma;

endmodule // hub_power_port_config_regs

// [tb/hub_cfg_host_model.sv]
// Host model that writes and reads the hub configuration registers.
`timescale 1ns/1ps
module hub_cfg_host_model
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rd_valid,
   input  wire logic [7:0] i_rd_data,
   output logic            o_wr_en,
   output logic      [7:0] o_wr_addr,
   output logic      [7:0] o_wr_data,
   output logic            o_rd_en,
   output logic      [7:0] o_rd_addr
);
   // Idle bus at time zero.
   initial
   begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_wr_addr = 8'h00;
      o_wr_data = 8'h00;
      o_rd_addr = 8'h00;
   end

   // A raw write skips the host's own care, so that reserved bits and unmasked bytes reach the bank.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input bit raw);
      logic [7:0] v;
      v = d;
      if (!raw)
      begin
         case (a)
            8'h07: v = d & 8'hAE;
            8'h08: v = d & 8'hB8;
            8'h09, 8'h0A, 8'h0B: v = d & 8'h06;
            8'h0C: v = (d > 8'h32) ? 8'h32 : d;
            default: v = 8'h00;
         endcase
         if (a == 8'h07 && v[7] && v[2])
            v[2] = 1'b0;
      end
      @(posedge i_clk_sys);
      #1;
      o_wr_en = 1'b1;
      o_wr_addr = a;
      o_wr_data = v;
      @(posedge i_clk_sys);
      #1;
      o_wr_en = 1'b0;
      o_wr_addr = ~a;
      o_wr_data = ~v; // Released data no longer shows the byte.
   endtask

   // Read data is taken one nanosecond after the edge that samples the strobe.
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      #1;
      o_rd_en = 1'b1;
      o_rd_addr = a;
      @(posedge i_clk_sys);
      #1;
      o_rd_en = 1'b0;
      o_rd_addr = ~a;
      d = i_rd_valid ? i_rd_data : 8'hXX;
   endtask
endmodule // hub_cfg_host_model

// [tb/hub_cfg_regs_asserts.sv]
// Port checker for the hub configuration register bank.
`timescale 1ns/1ps
module hub_cfg_regs_asserts
(
   input wire logic       i_clk_sys,
   input wire logic       i_rstn,
   input wire logic       i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic       i_rd_en,
   input wire logic       i_config_lock,
   input wire logic       i_mem_clear,
   input wire logic [7:0] o_rd_data,
   input wire logic       o_rd_valid,
   input wire logic       o_wr_refused,
   input wire logic       o_full_speed_only,
   input wire logic       o_frame_end_marker_off,
   input wire logic       o_overload_sense_ganged,
   input wire logic       o_dynamic_switch_en,
   input wire logic       o_compound_device,
   input wire logic [1:0] o_fixed_port_mask,
   input wire logic [7:0] o_self_power_max_draw_value,
   input wire logic [8:0] o_self_power_max_draw_ma
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);

   // An accepted write; the lock window covers every register here.
   logic wr_ok;
   assign wr_ok = i_wr_en && !i_config_lock && !i_mem_clear;

   // A decoded output shows the written bit two edges after the write.
   property p_bit(a, b, o);
      wr_ok && i_wr_addr == a |=> ##1 o == $past(i_wr_data[b], 2);
   endproperty

   a_fs_only_bit: assert property (p_bit(8'h07, 5, o_full_speed_only))
      else $error("full speed only does not follow byte one");
   a_eop_off_bit: assert property (p_bit(8'h07, 3, o_frame_end_marker_off))
      else $error("frame end marker control does not follow byte one");
   a_dynamic_bit: assert property (p_bit(8'h08, 7, o_dynamic_switch_en))
      else $error("dynamic switching does not follow byte two");
   a_compound_bit: assert property (p_bit(8'h08, 3, o_compound_device))
      else $error("compound flag does not follow byte two");
   a_sense_mode: assert property (wr_ok && i_wr_addr == 8'h07 |=> ##1
      o_overload_sense_ganged == ($past(i_wr_data[2:1], 2) == 2'b00))
      else $error("ganged sensing does not match the sense code");
   a_fixed_ports: assert property (wr_ok && i_wr_addr == 8'h09 |=> ##1
      o_fixed_port_mask == $past(i_wr_data[2:1], 2))
      else $error("fixed port mask does not follow its register");
   a_lock_refuse: assert property (i_wr_en && i_config_lock && !i_mem_clear
      && i_wr_addr inside {[8'h01:8'h10]} |=> o_wr_refused)
      else $error("locked write was not refused");
   a_refuse_cause: assert property (o_wr_refused |-> $past(i_wr_en && i_config_lock))
      else $error("refusal without a locked write");
   a_read_answer: assert property (o_rd_valid == $past(i_rd_en))
      else $error("read valid not one cycle after the strobe");
   a_rd_data_hold: assert property (!$past(i_rd_en) |-> $stable(o_rd_data))
      else $error("read data moved without a read");
   a_draw_in_ma: assert property (o_self_power_max_draw_ma ==
      {$past(o_self_power_max_draw_value), 1'b0})
      else $error("draw in milliamps is not twice the value");

   c_refused: cover property (o_wr_refused);
   c_read: cover property (o_rd_valid);
   c_no_sense: cover property ($fell(o_overload_sense_ganged));
endmodule // hub_cfg_regs_asserts

bind hub_power_port_config_regs hub_cfg_regs_asserts u_hub_cfg_regs_asserts
(
   .i_clk_sys, .i_rstn, .i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_en, .i_config_lock,
   .i_mem_clear, .o_rd_data, .o_rd_valid, .o_wr_refused, .o_full_speed_only,
   .o_frame_end_marker_off, .o_overload_sense_ganged, .o_dynamic_switch_en,
   .o_compound_device, .o_fixed_port_mask, .o_self_power_max_draw_value,
   .o_self_power_max_draw_ma
);

// [tb/testbench.sv]
// Self-checking bench for the hub configuration register bank.
`timescale 1ns/1ps
module testbench;
   import hub_cfg_pkg::*;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q; bit raw;} row_s;
   localparam int unsigned CYC [4] = '{5, 10, 15, 20};
   logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_config_lock = 1'b0, i_mem_clear = 1'b0;
   logic i_local_supply_sense_pin = 1'b0, i_overload_pin_n = 1'b1;
   logic wr_en, rd_en, rd_valid, wr_refused, pwr_sel, fs_only, eop_off, ganged;
   logic fault, dyn_en, compound;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data, draw, q;
   logic [1:0] fixed_mask, port_en;
   logic [8:0] draw_ma;
   int fails = 0, num_checks = 0, cycles = 0, n;
   // Write, read back: plain values, reserved bits, unmapped offsets.
   row_s rows [10] = '{'{8'h07, 8'hA8, 8'hA8, 0}, '{8'h08, 8'h38, 8'h38, 0},
      '{8'h09, 8'hFF, 8'h06, 1}, '{8'h09, 8'h06, 8'h06, 0}, '{8'h0A, 8'hFF, 8'h06, 1},
      '{8'h0A, 8'h04, 8'h04, 0}, '{8'h0B, 8'h02, 8'h02, 0}, '{8'h0C, 8'h32, 8'h32, 0},
      '{8'h20, 8'h5A, 8'h00, 1}, '{8'h0D, 8'h5A, 8'h00, 1}};

   always #5 i_clk_sys = ~i_clk_sys;

   hub_power_port_config_regs #(.OC_CYC_0(5), .OC_CYC_1(10), .OC_CYC_2(15), .OC_CYC_3(20))
   u_hub_power_port_config_regs
   (
      .i_clk_sys, .i_rstn, .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
      .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_config_lock, .i_mem_clear,
      .i_local_supply_sense_pin, .i_overload_pin_n, .o_rd_data(rd_data),
      .o_rd_valid(rd_valid), .o_wr_refused(wr_refused), .o_power_source_select(pwr_sel),
      .o_full_speed_only(fs_only), .o_frame_end_marker_off(eop_off),
      .o_overload_sense_ganged(ganged), .o_overload_fault(fault),
      .o_dynamic_switch_en(dyn_en), .o_compound_device(compound),
      .o_fixed_port_mask(fixed_mask), .o_port_enabled(port_en),
      .o_self_power_max_draw_value(draw), .o_self_power_max_draw_ma(draw_ma)
   );

   hub_cfg_host_model u_hub_cfg_host_model
   (
      .i_clk_sys, .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wr_en(wr_en),
      .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr)
   );

   task automatic wrap_up;
      if (fails == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      cmp_val({8'h00, got}, {8'h00, exp});
   endtask

   // Inputs change one nanosecond after the edge.
   task automatic step(input int k);
      repeat (k) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_hub_cfg_host_model.write_reg(a, d, 0);
   endtask

   // A hang is cut short well beyond the expected run length.
   always @(posedge i_clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         fails++;
         wrap_up();
      end
   end

   initial
   begin
      step(12);
      i_rstn = 1'b1;
      for (int a = 7; a <= 12; a++)
      begin
         u_hub_cfg_host_model.read_reg(a[7:0], q);
         cmp_val(q, 9'h000);
      end
      foreach (rows[i])
      begin
         u_hub_cfg_host_model.write_reg(rows[i].a, rows[i].d, rows[i].raw);
         u_hub_cfg_host_model.read_reg(rows[i].a, q);
         cmp_val(q, rows[i].q);
      end
      step(2);
      cmp_flag(pwr_sel, 1'b1);
      cmp_flag(fs_only, 1'b1);
      cmp_flag(eop_off, 1'b1);
      cmp_flag(ganged, 1'b1);
      cmp_flag(dyn_en, 1'b0);
      cmp_flag(compound, 1'b1);
      cmp_val(fixed_mask, 9'h003);
      cmp_val(port_en, 9'h001);
      cmp_val(draw, 9'h032);
      cmp_val(draw_ma, 9'h064);
      // Bus power uses the other disable register.
      wr(8'h07, 8'h28);
      step(3);
      cmp_flag(pwr_sel, 1'b0);
      cmp_val(port_en, 9'h002);
      // Dynamic switching: the stored bit says bus, the pin decides.
      wr(8'h08, 8'hB8);
      for (int s = 1; s >= 0; s--)
      begin
         i_local_supply_sense_pin = s[0];
         step(5);
         cmp_flag(pwr_sel, s[0]);
         cmp_val(port_en, s[0] ? 9'h001 : 9'h002);
      end
      wr(8'h08, 8'h38);
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h07, {5'h00, c[1:0], 1'b0});
         step(3);
         cmp_flag(ganged, c == 0);
      end
      // Each delay code: the fault rises only after its own count.
      wr(8'h07, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h08, {2'h0, c[1:0], 4'h0});
         step(3);
         i_overload_pin_n = 1'b0;
         n = 0;
         while (fault !== 1'b1 && n < 40)
         begin
            step(1);
            n++;
         end
         cmp_flag(n > CYC[c] && n <= CYC[c] + 4, 1'b1);
         i_overload_pin_n = 1'b1;
         step(6);
         cmp_flag(fault, 1'b0);
      end
      // Locked writes are refused and leave the register alone.
      i_config_lock = 1'b1;
      u_hub_cfg_host_model.write_reg(8'h07, 8'hFF, 1);
      cmp_flag(wr_refused, 1'b1);
      u_hub_cfg_host_model.read_reg(8'h07, q);
      cmp_val(q, 9'h000);
      i_config_lock = 1'b0;
      // Soft clear, then a hardware reset in mid-run.
      wr(8'h0C, 8'h32);
      i_mem_clear = 1'b1;
      step(1);
      i_mem_clear = 1'b0;
      u_hub_cfg_host_model.read_reg(8'h0C, q);
      cmp_val(q, 9'h000);
      wr(8'h09, 8'h06);
      i_rstn = 1'b0;
      step(3);
      i_rstn = 1'b1;
      u_hub_cfg_host_model.read_reg(8'h09, q);
      cmp_val(q, 9'h000);
      wrap_up();
   end
endmodule // testbench
